// ===== cpu_return_trap_alu_ops.sv
// Purpose: executes returns, trap and shift/subtract/xor instructions
// Assumes: decoded instruction arrives as a one-cycle start pulse
// Notes:   address stack pop data supplied by the stack owner, push data built here
// Functional notes
// (RULE1) flag-conditional return acts only when selected flag equals state bit
// (RULE2) interrupt-enable action: 0 keep, 1 restore, 2 set, 3 clear
// (RULE3) context restore reloads n z c v and bank selection from stack
// (RULE4) condition codes test one flag for either polarity
// (RULE5) selector 0-3 picks z c v n, 4-7 picks transceiver status flags
// (RULE6) unconditional return always pops stack into program counter
// (RULE7) rotate right 0-7, last wrapped bit to carry, n z updated
// (RULE8) shift left 0-7 with zero fill, carry is last bit out
// (RULE9) shift right 0-7 with zero fill, carry is last bit out
// (RULE10) subtract with borrow: source minus accumulator minus carry
// (RULE11) immediate subtract on r0-r15 writes back, updates n z c v
// (RULE12) accumulator subtract: source minus accumulator, n z c v
// (RULE13) accumulator is the one chosen by current bank selection
// (RULE14) trap pushes pc, interrupt enable, flags and bank selection; code pushes stack_top_i[15:0] in place of pc
// (RULE15) trap target is vector base concatenated with zero-extended vector
// (RULE16) trap clears interrupt enable when operand is 1, flags untouched
// (RULE17) hardware sources use vectors 28, 4, 8, 12, 16, 20
// (RULE18) immediate xor on r0-r15 writes back, updates n and z only
// (RULE19) conditional return takes two states false, three states true
// (RULE20) flags not affected by an instruction keep their value
`timescale 1ns/100ps
`default_nettype none
module cpu_return_trap_alu_ops (
	// clock and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 reset_n_i,
	// decoded instruction
	input  wire logic                 start_i,
	input  wire cpu_exec_pkg::op_type op_i,
	input  wire logic [2:0]           flag_sel_i,
	input  wire logic                 state_bit_i,
	input  wire logic [1:0]           gie_action_i,
	input  wire logic                 context_restore_sel_i,
	input  wire logic                 trap_gie_clr_i,
	input  wire logic [5:0]           vector_i,
	input  wire logic [2:0]           amount_i,
	input  wire logic [7:0]           imm_i,
	input  wire logic [7:0]           src_data_i,
	input  wire logic [4:0]           dest_sel_i,
	input  wire logic                 dest_mem_i,
	// accumulators by bank
	input  wire logic [7:0]           acc_main_i,
	input  wire logic [7:0]           acc_alt_i,
	// transceiver status (same clock)
	input  wire logic                 receiver_active_flag_i,
	input  wire logic                 rx_fault_flag_i,
	input  wire logic                 data_available_flag_i,
	input  wire logic                 tx_fifo_full_flag_i,
	// vector base and hardware interrupt sources
	input  wire logic [7:0]           vector_base_reg_i,
	input  wire logic                 nmi_irq_i,
	input  wire logic                 receiver_irq_group_i,
	input  wire logic                 tx_fifo_empty_irq_i,
	input  wire logic                 vector_12_source_i,
	input  wire logic                 host_bus_irq_i,
	input  wire logic                 timer_expiry_irq_i,
	// address stack top
	input  wire logic [24:0]          stack_top_i,
	// results
	output logic                      busy_o,
	output logic                      done_o,
	output logic [15:0]               pc_o,
	output logic                      pc_load_o,
	output logic                      global_irq_enable_o,
	output logic [3:0]                alu_flag_reg_o,
	output logic [3:0]                bank_sel_o,
	output logic                      stack_push_o,
	output logic                      stack_pop_o,
	output logic [24:0]               stack_push_data_o,
	output logic                      reg_we_o,
	output logic                      mem_we_o,
	output logic [4:0]                wr_addr_o,
	output logic [7:0]                wr_data_o,
	output logic                      hw_vec_valid_o,
	output logic [5:0]                hw_vec_o
);
	typedef enum logic [1:0] {S_IDLE, S_STATE2, S_STATE3} phase_type;

	phase_type              phase_r;
	logic                   taken_r;
	logic [1:0]             gie_act_r;
	logic                   restore_r;
	logic                   tested_flag;
	logic                   cond_ok;
	logic                   is_pop;
	logic [7:0]             acc_active;
	logic [7:0]             alu_opnd;
	logic [7:0]             alu_res;
	logic [3:0]             alu_flags;
	logic [15:0]            trap_target;
	logic                   is_alu;

	// flag selector decode
	function automatic logic sel_flag(input logic [2:0] sel, input logic [3:0] fl,
	                                  input logic ra, input logic re,
	                                  input logic data_available_flag, input logic tx_fifo_full_flag);
		logic r;
		r = 1'b0;
		unique case (sel)
			3'h0: r = fl[cpu_exec_pkg::FLAG_Z];
			3'h1: r = fl[cpu_exec_pkg::FLAG_C];
			3'h2: r = fl[cpu_exec_pkg::FLAG_V];
			3'h3: r = fl[cpu_exec_pkg::FLAG_N];
			3'h4: r = ra;
			3'h5: r = re;
			3'h6: r = data_available_flag;
			3'h7: r = tx_fifo_full_flag;
		endcase
		return r;
	endfunction : sel_flag

	assign tested_flag = sel_flag(flag_sel_i, alu_flag_reg_o, receiver_active_flag_i,
	                              rx_fault_flag_i, data_available_flag_i,
	                              tx_fifo_full_flag_i); // RULE5
	assign cond_ok     = (op_i == cpu_exec_pkg::OP_UNCOND_POP) ||
	                     (tested_flag == state_bit_i); // RULE1 RULE4
	assign is_pop      = (op_i == cpu_exec_pkg::OP_FLAG_POP) ||
	                     (op_i == cpu_exec_pkg::OP_COND_POP) ||
	                     (op_i == cpu_exec_pkg::OP_UNCOND_POP);
	assign acc_active  = bank_sel_o[0] ? acc_alt_i : acc_main_i; // RULE13
	assign alu_opnd    = (op_i == cpu_exec_pkg::OP_SUB_IMM ||
	                      op_i == cpu_exec_pkg::OP_XOR_IMM) ? imm_i : acc_active;
	assign trap_target = {vector_base_reg_i, 2'b00, vector_i}; // RULE15
	assign is_alu      = op_i inside {cpu_exec_pkg::OP_ROT_RIGHT,
	                                  cpu_exec_pkg::OP_SHIFT_LEFT,
	                                  cpu_exec_pkg::OP_SHIFT_RIGHT,
	                                  cpu_exec_pkg::OP_SUB_BORROW,
	                                  cpu_exec_pkg::OP_SUB_IMM,
	                                  cpu_exec_pkg::OP_SUB_ACC,
	                                  cpu_exec_pkg::OP_XOR_IMM};

	cpu_alu_unit u_alu (
		.op_i     (op_i),
		.amount_i (amount_i),
		.src_i    (src_data_i),
		.opnd_i   (alu_opnd),
		.flags_i  (alu_flag_reg_o),
		.result_o (alu_res),
		.flags_o  (alu_flags)
	);

	// instruction sequencing
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_r   <= S_IDLE;
			taken_r   <= 1'b0;
			gie_act_r <= cpu_exec_pkg::GIE_KEEP;
			restore_r <= 1'b0;
			busy_o    <= 1'b0;
			done_o    <= 1'b0;
		end else begin
			done_o <= 1'b0;
			unique case (phase_r)
				S_IDLE: begin
					if (start_i) begin
						phase_r   <= S_STATE2;
						busy_o    <= 1'b1;
						taken_r   <= is_pop && cond_ok;
						gie_act_r <= gie_action_i;
						restore_r <= context_restore_sel_i;
					end
				end
				S_STATE2: begin
					if (taken_r && op_i != cpu_exec_pkg::OP_UNCOND_POP) begin
						phase_r <= S_STATE3; // RULE19
					end else begin
						phase_r <= S_IDLE;
						busy_o  <= 1'b0;
						done_o  <= 1'b1;
					end
				end
				S_STATE3: begin
					phase_r <= S_IDLE;
					busy_o  <= 1'b0;
					done_o  <= 1'b1;
				end
				default: begin
					phase_r <= S_IDLE;
				end
			endcase
		end
	end

	// program counter and stack strobes
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pc_o              <= cpu_exec_pkg::PC_RESET;
			pc_load_o         <= 1'b0;
			stack_pop_o       <= 1'b0;
			stack_push_o      <= 1'b0;
			stack_push_data_o <= '0;
		end else begin
			pc_load_o    <= 1'b0;
			stack_pop_o  <= 1'b0;
			stack_push_o <= 1'b0;
			if (start_i && phase_r == S_IDLE) begin
				if (is_pop && cond_ok) begin
					pc_o        <= stack_top_i[15:0]; // RULE6
					pc_load_o   <= 1'b1;
					stack_pop_o <= 1'b1;
				end else if (op_i == cpu_exec_pkg::OP_TRAP) begin
					stack_push_data_o <= {bank_sel_o, alu_flag_reg_o,
					                      global_irq_enable_o, stack_top_i[15:0]}; // RULE14
					stack_push_o      <= 1'b1;
					pc_o              <= trap_target;
					pc_load_o         <= 1'b1;
				end
			end
		end
	end

	// interrupt enable
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			global_irq_enable_o <= 1'b0;
		end else if (start_i && phase_r == S_IDLE) begin
			if (is_pop && cond_ok) begin
				unique case (gie_action_i) // RULE2
					cpu_exec_pkg::GIE_KEEP:    global_irq_enable_o <= global_irq_enable_o;
					cpu_exec_pkg::GIE_RESTORE: global_irq_enable_o <= stack_top_i[16];
					cpu_exec_pkg::GIE_SET:     global_irq_enable_o <= 1'b1;
					cpu_exec_pkg::GIE_CLEAR:   global_irq_enable_o <= 1'b0;
				endcase
			end else if (op_i == cpu_exec_pkg::OP_TRAP && trap_gie_clr_i) begin
				global_irq_enable_o <= 1'b0; // RULE16
			end
		end
	end

	// flags and bank selection
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			alu_flag_reg_o <= cpu_exec_pkg::FLAGS_RESET;
			bank_sel_o     <= cpu_exec_pkg::BANK_RESET;
		end else if (start_i && phase_r == S_IDLE) begin
			if (is_pop && cond_ok && context_restore_sel_i) begin
				alu_flag_reg_o <= stack_top_i[20:17]; // RULE3
				bank_sel_o     <= stack_top_i[24:21];
			end else if (is_alu) begin
				alu_flag_reg_o <= alu_flags; // RULE20
			end
		end
	end

	// result write-back
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_we_o  <= 1'b0;
			mem_we_o  <= 1'b0;
			wr_addr_o <= 5'h00;
			wr_data_o <= 8'h00;
		end else begin
			reg_we_o <= 1'b0;
			mem_we_o <= 1'b0;
			if (start_i && phase_r == S_IDLE && is_alu) begin
				wr_data_o <= alu_res;
				if (op_i == cpu_exec_pkg::OP_SUB_IMM || op_i == cpu_exec_pkg::OP_XOR_IMM) begin
					wr_addr_o <= {1'b0, dest_sel_i[3:0]}; // RULE11 RULE18
					reg_we_o  <= 1'b1;
				end else begin
					wr_addr_o <= dest_sel_i;
					mem_we_o  <= dest_mem_i && (op_i == cpu_exec_pkg::OP_SUB_BORROW ||
					                            op_i == cpu_exec_pkg::OP_SUB_ACC);
					reg_we_o  <= !(dest_mem_i && (op_i == cpu_exec_pkg::OP_SUB_BORROW ||
					                              op_i == cpu_exec_pkg::OP_SUB_ACC));
				end
			end
		end
	end

	// hardware vector priority
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hw_vec_valid_o <= 1'b0;
			hw_vec_o       <= 6'h00;
		end else begin
			hw_vec_valid_o <= nmi_irq_i | receiver_irq_group_i | tx_fifo_empty_irq_i |
			                  vector_12_source_i | host_bus_irq_i | timer_expiry_irq_i;
			if (nmi_irq_i)                 hw_vec_o <= cpu_exec_pkg::VEC_NMI; // RULE17
			else if (receiver_irq_group_i) hw_vec_o <= cpu_exec_pkg::VEC_RX_GRP;
			else if (tx_fifo_empty_irq_i)  hw_vec_o <= cpu_exec_pkg::VEC_TX_EMPT;
			else if (vector_12_source_i)   hw_vec_o <= cpu_exec_pkg::VEC_12_SRC;
			else if (host_bus_irq_i)       hw_vec_o <= cpu_exec_pkg::VEC_HOST;
			else if (timer_expiry_irq_i)   hw_vec_o <= cpu_exec_pkg::VEC_TIMER;
		end
	end

	// checks
	a_pop_needs_cond: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		stack_pop_o |-> $past(cond_ok)) else $error("pop without condition"); // RULE1
	a_gie_set_act: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && phase_r == S_IDLE && is_pop && cond_ok && gie_action_i == 2'h2)
		|=> global_irq_enable_o) else $error("gie not set"); // RULE2
	a_restore_flags: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && phase_r == S_IDLE && is_pop && cond_ok && context_restore_sel_i)
		|=> alu_flag_reg_o == $past(stack_top_i[20:17])) else $error("flags not restored"); // RULE3
	a_uncond_pops: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && phase_r == S_IDLE && op_i == cpu_exec_pkg::OP_UNCOND_POP)
		|=> stack_pop_o && pc_load_o) else $error("return did not pop"); // RULE6
	a_trap_target: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && phase_r == S_IDLE && op_i == cpu_exec_pkg::OP_TRAP)
		|=> stack_push_o && pc_o[15:8] == $past(vector_base_reg_i)
		    && pc_o[7:6] == 2'b00) else $error("trap target wrong"); // RULE15
	a_trap_no_flags: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && phase_r == S_IDLE && op_i == cpu_exec_pkg::OP_TRAP)
		|=> $stable(alu_flag_reg_o)) else $error("trap changed flags"); // RULE16
	a_true_three: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && phase_r == S_IDLE && is_pop && cond_ok &&
		 op_i != cpu_exec_pkg::OP_UNCOND_POP)
		|=> !done_o ##1 !done_o ##1 done_o) else $error("true return not 3 states"); // RULE19
	a_false_two: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && phase_r == S_IDLE && is_pop && !cond_ok)
		|=> !done_o ##1 done_o) else $error("false return not 2 states"); // RULE19
	a_xor_keeps_cv: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(start_i && phase_r == S_IDLE && op_i == cpu_exec_pkg::OP_XOR_IMM)
		|=> alu_flag_reg_o[2:1] == $past(alu_flag_reg_o[2:1])) else $error("xor hit c/v"); // RULE18
	c_trap: cover property (@(posedge clk_sys_i) stack_push_o);
	c_pop: cover property (@(posedge clk_sys_i) stack_pop_o);
	c_write: cover property (@(posedge clk_sys_i) reg_we_o);
endmodule : cpu_return_trap_alu_ops
`default_nettype wire

// ===== cpu_exec_pkg.sv
// Purpose: shared constants for the return, trap and alu execution block
// Assumes: 8-bit datapath, 16-bit program counter, 4-bit bank selection
// Notes:   operation codes are a local encoding of the decoded instruction
package cpu_exec_pkg;
	typedef enum logic [3:0] {
		OP_NONE,
		OP_FLAG_POP,
		OP_COND_POP,
		OP_UNCOND_POP,
		OP_ROT_RIGHT,
		OP_SHIFT_LEFT,
		OP_SHIFT_RIGHT,
		OP_SUB_BORROW,
		OP_SUB_IMM,
		OP_SUB_ACC,
		OP_XOR_IMM,
		OP_TRAP
	} op_type;

	// interrupt-enable action codes
	localparam logic [1:0] GIE_KEEP    = 2'h0;
	localparam logic [1:0] GIE_RESTORE = 2'h1;
	localparam logic [1:0] GIE_SET     = 2'h2;
	localparam logic [1:0] GIE_CLEAR   = 2'h3;

	// flag vector positions (n v c z, msb first)
	localparam int FLAG_Z = 0;
	localparam int FLAG_C = 1;
	localparam int FLAG_V = 2;
	localparam int FLAG_N = 3;

	// hardware vectors simulated by trap
	localparam logic [5:0] VEC_NMI     = 6'h1C;
	localparam logic [5:0] VEC_RX_GRP  = 6'h04;
	localparam logic [5:0] VEC_TX_EMPT = 6'h08;
	localparam logic [5:0] VEC_12_SRC  = 6'h0C;
	localparam logic [5:0] VEC_HOST    = 6'h10;
	localparam logic [5:0] VEC_TIMER   = 6'h14;

	// processor states per return outcome
	localparam logic [1:0] STATES_FALSE = 2'h2;
	localparam logic [1:0] STATES_TRUE  = 2'h3;

	// reset values
	localparam logic [15:0] PC_RESET    = 16'h0000;
	localparam logic [3:0]  FLAGS_RESET = 4'h0;
	localparam logic [3:0]  BANK_RESET  = 4'h0;

	// stack frame width: pc + gie + flags + bank
	localparam int FRAME_W = 25;
endpackage : cpu_exec_pkg

// ===== cpu_alu_unit.sv
// Purpose: combinational shift, rotate, subtract and xor unit
// Assumes: operands already selected by the executing block
// Notes:   flags returned as n z c v; unaffected flags pass through
`timescale 1ns/100ps
`default_nettype none
module cpu_alu_unit (
	// operation
	input  wire cpu_exec_pkg::op_type op_i,
	input  wire logic [2:0]           amount_i,
	// operands
	input  wire logic [7:0]           src_i,
	input  wire logic [7:0]           opnd_i,
	input  wire logic [3:0]           flags_i,
	// results
	output logic [7:0]                result_o,
	output logic [3:0]                flags_o
);
	logic [8:0]  diff;
	logic [15:0] dbl;
	logic [7:0]  circular_right_shift;
	logic        bor;

	always_comb begin
		flags_o  = flags_i;
		result_o = src_i;
		diff     = 9'h000;
		dbl      = {src_i, src_i} >> amount_i;
		circular_right_shift      = dbl[7:0];
		bor      = 1'b0;
		unique case (op_i)
			cpu_exec_pkg::OP_ROT_RIGHT: begin
				result_o = circular_right_shift;
				if (amount_i != 3'h0) begin
					flags_o[cpu_exec_pkg::FLAG_C] = circular_right_shift[7]; // RULE7
				end
			end
			cpu_exec_pkg::OP_SHIFT_LEFT: begin
				result_o = src_i << amount_i; // RULE8
				if (amount_i != 3'h0) begin
					flags_o[cpu_exec_pkg::FLAG_C] = src_i[3'h7 - amount_i + 3'h1];
				end
			end
			cpu_exec_pkg::OP_SHIFT_RIGHT: begin
				result_o = src_i >> amount_i; // RULE9
				if (amount_i != 3'h0) begin
					flags_o[cpu_exec_pkg::FLAG_C] = src_i[amount_i - 3'h1];
				end
			end
			cpu_exec_pkg::OP_SUB_BORROW,
			cpu_exec_pkg::OP_SUB_IMM,
			cpu_exec_pkg::OP_SUB_ACC: begin
				bor = (op_i == cpu_exec_pkg::OP_SUB_BORROW) ?
				      flags_i[cpu_exec_pkg::FLAG_C] : 1'b0; // RULE10
				diff = {1'b0, src_i} - {1'b0, opnd_i} - {8'h00, bor}; // RULE11 RULE12
				result_o = diff[7:0];
				flags_o[cpu_exec_pkg::FLAG_C] = diff[8];
				flags_o[cpu_exec_pkg::FLAG_V] = (src_i[7] ^ opnd_i[7]) & (src_i[7] ^ diff[7]);
			end
			cpu_exec_pkg::OP_XOR_IMM: begin
				result_o = src_i ^ opnd_i; // RULE18
			end
			default: begin
				result_o = src_i;
			end
		endcase
		if (op_i inside {cpu_exec_pkg::OP_ROT_RIGHT, cpu_exec_pkg::OP_SHIFT_LEFT,
		                 cpu_exec_pkg::OP_SHIFT_RIGHT, cpu_exec_pkg::OP_SUB_BORROW,
		                 cpu_exec_pkg::OP_SUB_IMM, cpu_exec_pkg::OP_SUB_ACC,
		                 cpu_exec_pkg::OP_XOR_IMM}) begin
			flags_o[cpu_exec_pkg::FLAG_N] = result_o[7]; // RULE20
			flags_o[cpu_exec_pkg::FLAG_Z] = (result_o == 8'h00);
		end
	end
endmodule : cpu_alu_unit
`default_nettype wire

// ===== cpu_return_trap_alu_ops_bench.sv
// Purpose: self-checking bench for the return, trap and alu execution block
// Assumes: one instruction at a time, next start issued in the done cycle
// Notes:   expected results queued by the driver, compared at done_o
`timescale 1ns/100ps
`default_nettype none
module cpu_return_trap_alu_ops_bench;
	typedef struct packed {
		logic [15:0] pc;
		logic [3:0]  fl;
		logic        global_irq_enable;
		logic [3:0]  bank;
		logic [7:0]  wd;
		logic [2:0]  we;
		logic [24:0] push;
		logic [2:0]  st;
		logic [4:0]  wa;
	} exp_type;

	logic                 clk_sys_i = 1'b0;
	logic                 reset_n_i;
	logic                 start_i, state_bit_i, context_restore_sel_i, trap_gie_clr_i, dest_mem_i;
	cpu_exec_pkg::op_type op_i;
	logic [2:0]           flag_sel_i, amount_i;
	logic [1:0]           gie_action_i;
	logic [5:0]           vector_i, hw_vec_o;
	logic [7:0]           imm_i, src_data_i, acc_main_i, acc_alt_i, vector_base_reg_i, wr_data_o;
	logic [4:0]           dest_sel_i, wr_addr_o;
	logic                 receiver_active_flag_i, rx_fault_flag_i;
	logic                 data_available_flag_i, tx_fifo_full_flag_i;
	logic                 nmi_irq_i, receiver_irq_group_i, tx_fifo_empty_irq_i;
	logic                 vector_12_source_i, host_bus_irq_i, timer_expiry_irq_i;
	logic [24:0]          stack_top_i, stack_push_data_o;
	logic                 busy_o, done_o, pc_load_o, global_irq_enable_o, hw_vec_valid_o;
	logic                 stack_push_o, stack_pop_o, reg_we_o, mem_we_o;
	logic [15:0]          pc_o, m_pc;
	logic [3:0]           alu_flag_reg_o, bank_sel_o, m_fl, m_bank;
	logic                 m_gie;
	logic [7:0]           m_wd;
	logic [4:0]           m_wa;
	logic [2:0]           cap;
	logic [24:0]          cpush;
	exp_type              q[$];
	exp_type              me;
	int                   cnt, err_total, compares;

	cpu_return_trap_alu_ops dut (
		.clk_sys_i, .reset_n_i, .start_i, .op_i, .flag_sel_i, .state_bit_i, .gie_action_i,
		.context_restore_sel_i, .trap_gie_clr_i, .vector_i, .amount_i, .imm_i, .src_data_i,
		.dest_sel_i, .dest_mem_i, .acc_main_i, .acc_alt_i, .receiver_active_flag_i,
		.rx_fault_flag_i, .data_available_flag_i, .tx_fifo_full_flag_i, .vector_base_reg_i,
		.nmi_irq_i, .receiver_irq_group_i, .tx_fifo_empty_irq_i, .vector_12_source_i,
		.host_bus_irq_i, .timer_expiry_irq_i, .stack_top_i, .busy_o, .done_o, .pc_o,
		.pc_load_o, .global_irq_enable_o, .alu_flag_reg_o, .bank_sel_o, .stack_push_o,
		.stack_pop_o, .stack_push_data_o, .reg_we_o, .mem_we_o, .wr_addr_o, .wr_data_o,
		.hw_vec_valid_o, .hw_vec_o
	);

	always #5 clk_sys_i = ~clk_sys_i;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// result monitor: compares held outputs and strobes at done
	always @(posedge clk_sys_i) begin
		if (done_o === 1'b1 && q.size() > 0) begin
			me = q.pop_front();
			chk(pc_o, me.pc);
			chk(alu_flag_reg_o, me.fl);
			chk(global_irq_enable_o, me.global_irq_enable);
			chk(bank_sel_o, me.bank);
			chk(wr_data_o, me.wd);
			chk(cap, me.we);
			chk(cpush, me.push);
			chk(cnt, me.st - 3'h1);
			chk(wr_addr_o, me.wa);
		end
		if (start_i === 1'b1 && busy_o === 1'b0) begin
			cnt = 0;
			cap = 3'h0;
			cpush = 25'h0000000;
		end else begin
			cnt++;
			cap |= {stack_pop_o, mem_we_o, reg_we_o};
			if (stack_push_o === 1'b1) cpush = stack_push_data_o;
		end
	end

	// issue one instruction with random operands and queue its outcome
	task automatic run_op(input cpu_exec_pkg::op_type op);
		exp_type    e;
		logic [8:0] d;
		logic [7:0] a, b, r, acc;
		logic [3:0] transceiver_status_reg;
		logic       c, v, f, hit, wr;
		int         k;
		op_i = op;
		{flag_sel_i, state_bit_i, gie_action_i, context_restore_sel_i, trap_gie_clr_i,
			vector_i, amount_i, imm_i, src_data_i, dest_sel_i} = 38'({$urandom, $urandom});
		{acc_main_i, acc_alt_i, vector_base_reg_i, receiver_active_flag_i, rx_fault_flag_i,
			data_available_flag_i, tx_fifo_full_flag_i} = 28'($urandom);
		stack_top_i = 25'($urandom);
		dest_mem_i = (op == cpu_exec_pkg::OP_SUB_BORROW || op == cpu_exec_pkg::OP_SUB_ACC)
			? 1'($urandom) : 1'b0;
		transceiver_status_reg = {tx_fifo_full_flag_i, data_available_flag_i, rx_fault_flag_i, receiver_active_flag_i};
		e = '0;
		e.st = 3'h2;
		a = src_data_i;
		acc = m_bank[0] ? acc_alt_i : acc_main_i;
		k = int'(amount_i);
		r = a;
		c = m_fl[1];
		v = m_fl[2];
		wr = 1'b1;
		case (op)
			cpu_exec_pkg::OP_ROT_RIGHT: begin
				r = 8'({a, a} >> k);
				if (k != 0) c = r[7];
			end
			cpu_exec_pkg::OP_SHIFT_LEFT: begin
				r = a << k;
				if (k != 0) c = a[8 - k];
			end
			cpu_exec_pkg::OP_SHIFT_RIGHT: begin
				r = a >> k;
				if (k != 0) c = a[k - 1];
			end
			cpu_exec_pkg::OP_XOR_IMM: r = a ^ imm_i;
			cpu_exec_pkg::OP_SUB_BORROW, cpu_exec_pkg::OP_SUB_IMM, cpu_exec_pkg::OP_SUB_ACC: begin
				b = (op == cpu_exec_pkg::OP_SUB_IMM) ? imm_i : acc;
				d = {1'b0, a} - {1'b0, b} - 9'(op == cpu_exec_pkg::OP_SUB_BORROW && m_fl[1]);
				r = d[7:0];
				c = d[8];
				v = (a[7] ^ b[7]) & (a[7] ^ r[7]);
			end
			cpu_exec_pkg::OP_TRAP: begin
				wr = 1'b0;
				e.push = {m_bank, m_fl, m_gie, stack_top_i[15:0]};
				m_pc = {vector_base_reg_i, 2'h0, vector_i};
				if (trap_gie_clr_i) m_gie = 1'b0;
			end
			default: begin
				wr = 1'b0;
				f = flag_sel_i[2] ? transceiver_status_reg[flag_sel_i[1:0]] : m_fl[flag_sel_i[1:0]];
				hit = (op == cpu_exec_pkg::OP_UNCOND_POP) || (f == state_bit_i);
				if (op != cpu_exec_pkg::OP_UNCOND_POP && hit) e.st = 3'h3;
				if (hit) begin
					e.we = 3'h4;
					m_pc = stack_top_i[15:0];
					if (gie_action_i == 2'h1) m_gie = stack_top_i[16];
					if (gie_action_i == 2'h2) m_gie = 1'b1;
					if (gie_action_i == 2'h3) m_gie = 1'b0;
					if (context_restore_sel_i) {m_bank, m_fl} = stack_top_i[24:17];
				end
			end
		endcase
		if (wr) begin
			m_fl = {r[7], v, c, r == 8'h00};
			m_wd = r;
			m_wa = (op == cpu_exec_pkg::OP_SUB_IMM || op == cpu_exec_pkg::OP_XOR_IMM)
				? {1'b0, dest_sel_i[3:0]} : dest_sel_i;
			e.we = dest_mem_i ? 3'h2 : 3'h1;
		end
		{e.pc, e.fl, e.global_irq_enable, e.bank, e.wd} = {m_pc, m_fl, m_gie, m_bank, m_wd};
		e.wa = m_wa;
		q.push_back(e);
		start_i = 1'b1;
		@(posedge clk_sys_i);
		#1 start_i = 1'b0;
		for (int i = 0; i < 10 && done_o !== 1'b1; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
	endtask : run_op

	// hardware source vectors, nmi first then table order
	task automatic hw_test;
		logic [5:0] irq, v;
		for (int i = 0; i < 40; i++) begin
			irq = 6'($urandom);
			{nmi_irq_i, receiver_irq_group_i, tx_fifo_empty_irq_i, vector_12_source_i,
				host_bus_irq_i, timer_expiry_irq_i} = irq;
			v = irq[5] ? cpu_exec_pkg::VEC_NMI : irq[4] ? cpu_exec_pkg::VEC_RX_GRP :
				irq[3] ? cpu_exec_pkg::VEC_TX_EMPT : irq[2] ? cpu_exec_pkg::VEC_12_SRC :
				irq[1] ? cpu_exec_pkg::VEC_HOST : cpu_exec_pkg::VEC_TIMER;
			repeat (2) @(posedge clk_sys_i);
			#1;
			chk(hw_vec_valid_o, irq != 6'h00);
			if (irq != 6'h00) chk(hw_vec_o, v);
		end
	endtask : hw_test

	initial begin
		#500000;
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		void'($urandom(55));
		reset_n_i = 1'b0;
		op_i = cpu_exec_pkg::OP_NONE;
		{start_i, state_bit_i, context_restore_sel_i, trap_gie_clr_i, dest_mem_i, flag_sel_i,
			amount_i, gie_action_i, vector_i, imm_i, src_data_i, acc_main_i, acc_alt_i,
			vector_base_reg_i, dest_sel_i, receiver_active_flag_i, rx_fault_flag_i,
			data_available_flag_i, tx_fifo_full_flag_i, nmi_irq_i, receiver_irq_group_i,
			tx_fifo_empty_irq_i, vector_12_source_i, host_bus_irq_i, timer_expiry_irq_i,
			stack_top_i} = '0;
		{m_pc, m_fl, m_bank, m_gie, m_wd, m_wa} = '0;
		repeat (6) @(posedge clk_sys_i);
		#1 reset_n_i = 1'b1;
		chk({busy_o, done_o, pc_o, alu_flag_reg_o, bank_sel_o}, 32'h0);
		for (int i = 0; i < 600; i++) run_op(cpu_exec_pkg::op_type'(4'(1 + $urandom % 11)));
		repeat (2) @(posedge clk_sys_i);
		chk(q.size(), 0);
		$display("instruction sequence test done");
		#1 hw_test();
		$display("hardware vector test done");
		summarize();
	end
endmodule : cpu_return_trap_alu_ops_bench
`default_nettype wire
